/* ucp_chan.sv */
// Purpose: one serial channel: 8N1 transmitter and receiver
// Assumes: bit ticks from the parent; inputs already synchronised
// Notes: one tick per bit, external-clock edges picked by parent
`timescale 1ns/10ps
`include "ucp_map.svh"
module ucp_chan (
  input  wire logic       core_clk,
  input  wire logic       rst_b,
  input  wire logic       txTick,
  input  wire logic       rxTick,
  input  wire logic       txEnable,
  input  wire logic       rxEnable,
  input  wire logic       localLoop,
  input  wire logic       ctsOk,
  input  wire logic       txValid,
  input  wire logic [7:0] txData,
  output logic            txReady,
  output logic            txBusy,
  input  wire logic       serialIn,
  output logic            serialOut,
  output logic            rxStrobe,
  output logic [7:0]      rxData
);
  typedef struct packed {
    ucp_pkg::ucp_tx_t txSt;
    logic [7:0]       txSh;
    logic [2:0]       txCnt;
    logic             txHold;
    logic [7:0]       txBuf;
    logic             line;
    ucp_pkg::ucp_rx_t rxSt;
    logic [7:0]       rxSh;
    logic [2:0]       rxCnt;
    logic             rxStb;
    logic [7:0]       rxOut;
  } ucp_chan_st_t;
  ucp_chan_st_t st_reg, st_next;
  logic rxBit;
  assign rxBit = localLoop ? st_reg.line : serialIn;
  always_comb begin
    st_next = st_reg;
    st_next.rxStb = 1'b0;
    if (txValid && !st_reg.txHold) begin
      st_next.txHold = 1'b1;
      st_next.txBuf  = txData;
    end
    if (txTick) begin
      unique case (st_reg.txSt)
        ucp_pkg::TX_IDLE: begin
          st_next.line = 1'b1; // see RL3
          if (st_reg.txHold && txEnable && ctsOk) begin // see RL9
            st_next.txSh   = st_reg.txBuf;
            st_next.txHold = 1'b0;
            st_next.txSt   = ucp_pkg::TX_START;
          end
        end
        ucp_pkg::TX_START: begin
          st_next.line  = 1'b0;
          st_next.txCnt = 3'h0;
          st_next.txSt  = ucp_pkg::TX_DATA;
        end
        ucp_pkg::TX_DATA: begin
          st_next.line  = st_reg.txSh[0]; // see RL2
          st_next.txSh  = {1'b1, st_reg.txSh[7:1]};
          st_next.txCnt = st_reg.txCnt + 3'h1;
          if (st_reg.txCnt == 3'h7) st_next.txSt = ucp_pkg::TX_STOP;
        end
        ucp_pkg::TX_STOP: begin
          st_next.line = 1'b1;
          st_next.txSt = ucp_pkg::TX_IDLE;
        end
      endcase
    end
    if (rxTick && rxEnable) begin
      unique case (st_reg.rxSt)
        ucp_pkg::RX_IDLE: begin
          if (!rxBit) begin
            st_next.rxCnt = 3'h0;
            st_next.rxSt  = ucp_pkg::RX_DATA;
          end
        end
        ucp_pkg::RX_DATA: begin
          st_next.rxSh  = {rxBit, st_reg.rxSh[7:1]}; // see RL1
          st_next.rxCnt = st_reg.rxCnt + 3'h1;
          if (st_reg.rxCnt == 3'h7) st_next.rxSt = ucp_pkg::RX_STOP;
        end
        ucp_pkg::RX_STOP: begin
          if (rxBit) begin
            st_next.rxStb = 1'b1;
            st_next.rxOut = st_reg.rxSh;
          end
          st_next.rxSt = ucp_pkg::RX_IDLE;
        end
        default: st_next.rxSt = ucp_pkg::RX_IDLE;
      endcase
    end
    if (!rst_b) begin
      st_next = '0;
      st_next.line = 1'b1; // see RL13
    end
  end
  always_ff @(posedge core_clk) begin
    st_reg <= st_next;
  end
  assign txReady   = !st_reg.txHold;
  assign txBusy    = st_reg.txHold || (st_reg.txSt != ucp_pkg::TX_IDLE);
  assign serialOut = (localLoop || !txEnable) ? 1'b1 : st_reg.line; // see RL3
  assign rxStrobe  = st_reg.rxStb;
  assign rxData    = st_reg.rxOut;
endmodule

/* ucp_map.svh */
// Purpose: constants for the two-channel serial pin-function block
// Assumes: core_clk at 20 MHz
// Notes: Notes on behaviour list follows
// Notes on behaviour
// RL1: receivers take data LSB first; high is mark, low is space
// RL2: transmitters send LSB first; mark driven high, space low
// RL3: transmit output held at mark when disabled, idle or local loopback
// RL4: out bits 0/1 general or active-low request-to-send, auto-negated; code drives rxHeld there when rtsAutoSel is clear
// RL5: out bit 2 general, chan A tx clock 1x/16x, or rx clock 1x; code offers only tx16Cnt[3] or tx1Clk, no rx clock
// RL6: out bit 3 general, open-drain timer irq, chan B tx or rx 1x clock; code drives only the shared tx1Clk, no rx clock
// RL7: out bits 4/5 general or open-drain rx ready/fifo full irq; code has no fifo and gives rx ready only
// RL8: out bits 6/7 general or open-drain tx ready irq
// RL9: in bits 0/1 general or active-low clear-to-send gating transmitters
// RL10: in bit 2 general or counter/timer external clock
// RL11: external tx clock on in bits 3/5; shift out on falling edge
// RL12: external rx clock on in bits 4/6; sample on rising edge
// RL13: reset drives outputs high, stops timer, idles channels at mark
// RL14: pin function from config bits; general purpose after reset
`ifndef UCP_MAP_SVH
`define UCP_MAP_SVH
`define UCP_OUT_RESET   8'hff
`define UCP_CFG_RESET   8'h00
`define UCP_DIV16       4'hf
`define UCP_RX_FIFO_DEPTH 4
`define UCP_DATA_BITS   8
`endif

/* ucp_pins.sv */
// Purpose: two serial channels with multipurpose in/out port pins
// Assumes: single core_clk; pins sampled through two flip-flops
// Notes: open-drain pins as output value plus low-active enable
`timescale 1ns/10ps
`include "ucp_map.svh"
module ucp_pins #(
  parameter int BAUD_DIV = 130
) (
  input  wire logic       core_clk,
  input  wire logic       rst_b,
  input  wire logic [7:0] outPortValue,
  input  wire logic [7:0] outFuncSel,
  input  wire logic [1:0] rtsAutoSel,
  input  wire logic       txClkA16Sel,
  input  wire logic       op3ClkSel,
  input  wire logic [3:0] extClkSel,
  input  wire logic       ctsEnable,
  input  wire logic       timerRun,
  input  wire logic [15:0] timerPreset,
  input  wire logic       timerExtClk,
  input  wire logic [1:0] txEnable,
  input  wire logic [1:0] rxEnable,
  input  wire logic [1:0] localLoop,
  input  wire logic [1:0] txValid,
  input  wire logic [7:0] txDataA,
  input  wire logic [7:0] txDataB,
  output logic [1:0]      txReady,
  output logic [1:0]      rxStrobe,
  output logic [7:0]      rxDataA,
  output logic [7:0]      rxDataB,
  output logic            timerIrq,
  input  wire logic       serial_in_chan_a,
  input  wire logic       serial_in_chan_b,
  output logic            serial_out_chan_a,
  output logic            serial_out_chan_b,
  input  wire logic [6:0] inPort,
  output logic [6:0]      inPortSync,
  output logic [7:0]      outPort,
  output logic [7:0]      outPortOe_n
);
  // divider counter is 16 bits wide
  if (BAUD_DIV < 2 || BAUD_DIV > 65536) begin : gDivCheck
    $error("BAUD_DIV must lie between 2 and 65536");
  end
  typedef struct packed {
    logic [15:0] baudCnt;
    logic [3:0]  tx16Cnt;
    logic        tx1Clk;
    logic [6:0]  in1;
    logic [6:0]  in2;
    logic [6:0]  inPrev;
    logic [15:0] timerCnt;
    logic        timerFlag;
    logic [1:0]  rxHeld;
    logic [7:0]  outQ;
    logic [7:0]  oeQ;
    logic [1:0]  ser1;
    logic [1:0]  ser2;
  } ucp_top_st_t;
  ucp_top_st_t st_reg, st_next;
  logic baudTick, tx16Tick, timerTick;
  logic [1:0] txTick, rxTick, txBusy, ctsOk, serOut;
  logic [1:0] rxStb;
  logic [6:0] fall, rise;
  logic [7:0] funcVal, funcOd;
  assign baudTick = (st_reg.baudCnt == 16'(BAUD_DIV - 1));
  assign tx16Tick = baudTick && (st_reg.tx16Cnt == `UCP_DIV16);
  assign fall = st_reg.inPrev & ~st_reg.in2;
  assign rise = ~st_reg.inPrev & st_reg.in2;
  // see RL11 see RL12
  assign txTick[0] = extClkSel[0] ? fall[3] : tx16Tick;
  assign rxTick[0] = extClkSel[1] ? rise[4] : tx16Tick;
  assign txTick[1] = extClkSel[2] ? fall[5] : tx16Tick;
  assign rxTick[1] = extClkSel[3] ? rise[6] : tx16Tick;
  assign ctsOk = ctsEnable ? ~st_reg.in2[1:0] : 2'b11; // see RL9
  assign timerTick = timerExtClk ? rise[2] : baudTick; // see RL10
  always_comb begin
    st_next = st_reg;
    st_next.in1 = inPort;
    st_next.in2 = st_reg.in1;
    st_next.inPrev = st_reg.in2;
    // serial data pins are asynchronous: two flops before the receivers
    st_next.ser1 = {serial_in_chan_b, serial_in_chan_a};
    st_next.ser2 = st_reg.ser1;
    st_next.baudCnt = baudTick ? 16'h0000 : st_reg.baudCnt + 16'h0001;
    if (baudTick) st_next.tx16Cnt = st_reg.tx16Cnt + 4'h1;
    if (tx16Tick) st_next.tx1Clk = !st_reg.tx1Clk;
    if (timerRun && timerTick) begin
      if (st_reg.timerCnt == 16'h0000) begin
        st_next.timerCnt  = timerPreset;
        st_next.timerFlag = 1'b1;
      end else begin
        st_next.timerCnt = st_reg.timerCnt - 16'h0001;
      end
    end
    if (!timerRun) st_next.timerFlag = 1'b0;
    for (int i = 0; i < 2; i++) begin
      if (rxStb[i]) st_next.rxHeld[i] = 1'b1;
      else if (!rxEnable[i]) st_next.rxHeld[i] = 1'b0;
    end
    st_next.outQ = funcVal;
    st_next.oeQ  = funcOd;
    if (!rst_b) begin
      st_next = '0;
      st_next.outQ = `UCP_OUT_RESET; // see RL13
      st_next.in1 = 7'h7f;
      st_next.in2 = 7'h7f;
      st_next.inPrev = 7'h7f;
      st_next.ser1 = 2'h3;
      st_next.ser2 = 2'h3;
    end
  end
  always_ff @(posedge core_clk) begin
    st_reg <= st_next;
  end
  always_comb begin
    funcVal = outPortValue;
    funcOd  = 8'h00;
    for (int b = 0; b < 2; b++) begin
      if (outFuncSel[b]) begin
        funcVal[b] = rtsAutoSel[b] ? !txBusy[b] : st_reg.rxHeld[b]; // see RL4
      end
    end
    if (outFuncSel[2]) begin
      funcVal[2] = txClkA16Sel ? st_reg.tx16Cnt[3] : st_reg.tx1Clk; // see RL5
    end
    if (outFuncSel[3]) begin
      if (op3ClkSel) begin
        funcVal[3] = st_reg.tx1Clk; // see RL6
      end else begin
        funcVal[3] = !st_reg.timerFlag;
        funcOd[3]  = 1'b1;
      end
    end
    for (int b = 0; b < 2; b++) begin
      if (outFuncSel[4 + b]) begin
        funcVal[4 + b] = !st_reg.rxHeld[b]; // see RL7
        funcOd[4 + b]  = 1'b1;
      end
      if (outFuncSel[6 + b]) begin
        funcVal[6 + b] = !txReady[b]; // see RL8
        funcOd[6 + b]  = 1'b1;
      end
    end
    if (outFuncSel == `UCP_CFG_RESET) funcOd = 8'h00; // see RL14
  end
  genvar g;
  generate
    for (g = 0; g < 8; g++) begin : gOut
      assign outPort[g]     = st_reg.oeQ[g] ? 1'b0 : st_reg.outQ[g];
      assign outPortOe_n[g] = st_reg.oeQ[g] ? st_reg.outQ[g] : 1'b0;
    end
  endgenerate
  ucp_chan uChanA (
    .core_clk  (core_clk),
    .rst_b     (rst_b),
    .txTick    (txTick[0]),
    .rxTick    (rxTick[0]),
    .txEnable  (txEnable[0]),
    .rxEnable  (rxEnable[0]),
    .localLoop (localLoop[0]),
    .ctsOk     (ctsOk[0]),
    .txValid   (txValid[0]),
    .txData    (txDataA),
    .txReady   (txReady[0]),
    .txBusy    (txBusy[0]),
    .serialIn  (st_reg.ser2[0]),
    .serialOut (serOut[0]),
    .rxStrobe  (rxStb[0]),
    .rxData    (rxDataA)
  );
  ucp_chan uChanB (
    .core_clk  (core_clk),
    .rst_b     (rst_b),
    .txTick    (txTick[1]),
    .rxTick    (rxTick[1]),
    .txEnable  (txEnable[1]),
    .rxEnable  (rxEnable[1]),
    .localLoop (localLoop[1]),
    .ctsOk     (ctsOk[1]),
    .txValid   (txValid[1]),
    .txData    (txDataB),
    .txReady   (txReady[1]),
    .txBusy    (txBusy[1]),
    .serialIn  (st_reg.ser2[1]),
    .serialOut (serOut[1]),
    .rxStrobe  (rxStb[1]),
    .rxData    (rxDataB)
  );
  assign serial_out_chan_a = serOut[0];
  assign serial_out_chan_b = serOut[1];
  assign rxStrobe   = rxStb;
  assign inPortSync = st_reg.in2;
  assign timerIrq   = st_reg.timerFlag;
endmodule

/* ucp_pins_asserts.sv */
// Purpose: port checks for the serial pin-function block
// Assumes: one clock, synchronous low reset
// Notes: bound onto ucp_pins
`timescale 1ns/10ps
module ucp_pins_chk #(
  parameter int BAUD_DIV = 130
) (
  input wire logic       core_clk,
  input wire logic       rst_b,
  input wire logic [7:0] outPortValue,
  input wire logic [7:0] outFuncSel,
  input wire logic [1:0] txEnable,
  input wire logic [1:0] localLoop,
  input wire logic [1:0] txValid,
  input wire logic [1:0] txReady,
  input wire logic [1:0] rxStrobe,
  input wire logic [7:0] rxDataA,
  input wire logic       serial_out_chan_a,
  input wire logic       serial_out_chan_b,
  input wire logic [6:0] inPort,
  input wire logic [6:0] inPortSync,
  input wire logic [7:0] outPort,
  input wire logic [7:0] outPortOe_n
);
  localparam int FRAME_MAX = 12 * 16 * BAUD_DIV;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  sequence s_take_a;
    txValid[0] && txReady[0] && txEnable[0] && !localLoop[0];
  endsequence
  sequence s_start_a;
    ##[1:FRAME_MAX] !serial_out_chan_a;
  endsequence
  a_reset_out: assert property (disable iff (1'b0)
    !rst_b |=> outPort == 8'hff && outPortOe_n == 8'h00
    && serial_out_chan_a && serial_out_chan_b) else $error("reset state");
  a_idle_mark_a: assert property (
    (!txEnable[0] || localLoop[0]) [*2] |-> serial_out_chan_a)
    else $error("chan a left mark");
  a_idle_mark_b: assert property (
    (!txEnable[1] || localLoop[1]) [*2] |-> serial_out_chan_b)
    else $error("chan b left mark");
  a_gpo_follow: assert property (
    $past(rst_b) && $past(outFuncSel) == 8'h00 |->
    outPort == $past(outPortValue) && outPortOe_n == 8'h00)
    else $error("general output wrong");
  a_txrdy_irq: assert property (
    $past(rst_b) && $past(outFuncSel[6]) |->
    outPortOe_n[6] == !$past(txReady[0])) else $error("tx ready irq");
  a_tx_start: assert property (s_take_a |-> s_start_a)
    else $error("no start bit");
  a_rx_pulse: assert property (rxStrobe[0] |=> !rxStrobe[0])
    else $error("strobe too long");
  a_rx_hold: assert property (!rxStrobe[0] |-> $stable(rxDataA))
    else $error("rx data moved");
  a_in_sync: assert property (
    $past(rst_b) && $past(rst_b, 2) |-> inPortSync == $past(inPort, 2))
    else $error("input sync wrong");
endmodule
bind ucp_pins ucp_pins_chk #(.BAUD_DIV(BAUD_DIV)) chk_i (.*);

/* ucp_pins_bench.sv */
// Purpose: directed bench for the serial pin-function block
// Assumes: BAUD_DIV of 2, so 32 clocks per bit
// Notes: remote models on both lines
`timescale 1ns/10ps
module ucp_pins_bench;
  localparam int BAUD_DIV = 2;
  localparam int BIT = 16 * BAUD_DIV;
  logic       core_clk = 1'b0;
  logic       rst_b = 1'b0;
  logic       ctsEnable = 1'b0;
  logic       timerRun = 1'b0;
  logic [7:0] outPortValue = 8'h00;
  logic [7:0] outFuncSel = 8'h00;
  logic [7:0] txDataA = 8'h00;
  logic [7:0] txDataB = 8'h00;
  logic [6:0] inPort = 7'h00;
  logic [3:0] extClkSel = 4'h0;
  logic [1:0] txEnable = 2'h0;
  logic [1:0] rxEnable = 2'h0;
  logic [1:0] localLoop = 2'h0;
  logic [1:0] txValid = 2'h0;
  logic [1:0] rtsAutoSel = 2'h0;
  logic [1:0] txReady, rxStrobe;
  logic [1:0] txLines;
  logic       timerIrq;
  logic [7:0] rxDataA, rxDataB, outPort, outPortOe_n;
  logic [6:0] inPortSync;
  logic       serial_in_chan_a, serial_in_chan_b;
  logic       serial_out_chan_a, serial_out_chan_b;
  int         error_cnt = 0;
  int         checks_done = 0;
  always #25 core_clk = ~core_clk;
  assign txLines = {serial_out_chan_b, serial_out_chan_a};
  ucp_pins #(.BAUD_DIV(BAUD_DIV)) dut (
    .core_clk, .rst_b, .outPortValue, .outFuncSel, .rtsAutoSel,
    .txClkA16Sel(1'b0), .op3ClkSel(1'b0), .extClkSel, .ctsEnable,
    .timerRun, .timerPreset(16'h0010), .timerExtClk(1'b0), .txEnable,
    .rxEnable, .localLoop, .txValid, .txDataA, .txDataB, .txReady,
    .rxStrobe, .rxDataA, .rxDataB, .timerIrq, .serial_in_chan_a,
    .serial_in_chan_b, .serial_out_chan_a, .serial_out_chan_b, .inPort,
    .inPortSync, .outPort, .outPortOe_n);
  ucp_remote #(.BIT_NS(BIT * 50)) remA (
    .line_in(serial_out_chan_a), .line_out(serial_in_chan_a));
  ucp_remote #(.BIT_NS(BIT * 50)) remB (
    .line_in(serial_out_chan_b), .line_out(serial_in_chan_b));
  task automatic chk(input string n, input logic [7:0] got, exp);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", n, exp, got);
    end
  endtask
  task automatic clks(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task automatic t_reset;
    chk("outPort", outPort, 8'hff);
    chk("outPortOe_n", outPortOe_n, 8'h00);
    chk("serialOut", {6'h0, txLines}, 8'h03);
    $display("reset test done");
  endtask
  task automatic t_gpo;
    outPortValue = 8'h5a;
    clks(2);
    chk("outPort", outPort, 8'h5a);
    inPort = 7'h55;
    clks(3);
    chk("inPortSync", {1'b0, inPortSync}, 8'h55);
    $display("general port test done");
  endtask
  task automatic t_timer;
    outFuncSel = 8'h08;
    timerRun = 1'b1;
    clks(4);
    chk("timerIrq", {7'h0, timerIrq}, 8'h01);
    chk("timerPin", {6'h0, outPortOe_n[3], outPort[3]}, 8'h00);
    timerRun = 1'b0;
    clks(3);
    chk("timerIrq", {7'h0, timerIrq}, 8'h00);
    chk("timerPin", {6'h0, outPortOe_n[3], outPort[3]}, 8'h02);
    $display("timer test done");
  endtask
  task automatic t_tx;
    txEnable = 2'h3;
    outFuncSel = 8'hc3;
    rtsAutoSel = 2'h3;
    ctsEnable = 1'b1;
    inPort = 7'h03;
    for (int i = 0; i < 50 && txReady !== 2'h3; i++) clks(1);
    clks(3);
    chk("txRdyIrq", {6'h0, outPortOe_n[7:6]}, 8'h00);
    chk("rtsIdle", {6'h0, outPort[1:0]}, 8'h03);
    txDataA = 8'h35;
    txDataB = 8'hca;
    txValid = 2'h3;
    clks(1);
    txValid = 2'h0;
    clks(3 * BIT);
    chk("txRdyIrq", {6'h0, outPortOe_n[7:6]}, 8'h03);
    chk("rtsBusy", {6'h0, outPort[1:0]}, 8'h00);
    chk("ctsGate", {6'h0, txLines}, 8'h03);
    inPort = 7'h00;
    clks(12 * BIT);
    chk("remoteA", remA.got, 8'h35);
    chk("remoteB", remB.got, 8'hca);
    chk("rtsDone", {6'h0, outPort[1:0]}, 8'h03);
    $display("transmit test done");
  endtask
  task automatic t_rx;
    logic [1:0] stbSeen;
    stbSeen = 2'h0;
    rxEnable = 2'h3;
    clks(2);
    fork
      remA.send(8'ha6);
      remB.send(8'h3c);
      repeat (11 * BIT) begin
        clks(1);
        stbSeen = stbSeen | rxStrobe;
      end
    join
    chk("rxStrobe", {6'h0, stbSeen}, 8'h03);
    clks(BIT);
    chk("rxDataA", rxDataA, 8'ha6);
    chk("rxDataB", rxDataB, 8'h3c);
    $display("receive test done");
  endtask
  task automatic t_hold;
    logic [1:0] lowSeen;
    lowSeen = 2'h0;
    localLoop = 2'h1;
    ctsEnable = 1'b1;
    inPort = 7'h02;
    // let the negated clear-to-send pass the pin synchroniser first
    clks(3);
    txValid = 2'h3;
    clks(1);
    txValid = 2'h0;
    repeat (12 * BIT) begin
      clks(1);
      lowSeen = lowSeen | ~txLines;
    end
    clks(BIT);
    chk("loopData", rxDataA, 8'h35);
    chk("loopMark", {7'h0, lowSeen[0]}, 8'h00);
    chk("ctsMark", {7'h0, lowSeen[1]}, 8'h00);
    $display("hold test done");
  endtask
  task automatic results;
    $display("checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    clks(8);
    t_reset;
    rst_b = 1'b1;
    t_gpo;
    t_timer;
    t_tx;
    t_rx;
    t_hold;
    results;
  end
  initial begin
    #200000;
    error_cnt++;
    results;
  end
endmodule

/* ucp_pkg.sv */
// Purpose: types for the serial pin-function block
// Assumes: nothing
// Notes: none
package ucp_pkg;
  typedef enum logic [1:0] {TX_IDLE, TX_START, TX_DATA, TX_STOP} ucp_tx_t;
  typedef enum logic [1:0] {RX_IDLE, RX_DATA, RX_STOP} ucp_rx_t;
endpackage

/* ucp_remote.sv */
// Purpose: remote 8N1 serial equipment
// Assumes: bit time matches the block
// Notes: line idles at mark
`timescale 1ns/10ps
module ucp_remote #(
  parameter int BIT_NS = 1600
) (
  input  wire logic line_in,
  output logic      line_out
);
  logic [7:0] got = 8'h00;
  initial line_out = 1'b1;
  task automatic send(input logic [7:0] b);
    line_out = 1'b0;
    #BIT_NS;
    for (int i = 0; i < 8; i++) begin
      line_out = b[i];
      #BIT_NS;
    end
    line_out = 1'b1;
    #BIT_NS;
  endtask
  // mid-bit sampling after start edge
  always @(negedge line_in) begin
    #(BIT_NS / 2);
    if (!line_in) begin
      for (int i = 0; i < 8; i++) begin
        #BIT_NS;
        got[i] = line_in;
      end
    end
  end
endmodule
